/* File: hdl/hcs_pkg.sv */
// Purpose: shared constants and types for the cvd sequencer
// Assumes: 8-bit register port, 10-bit converter result
// Notes: offsets are word indices on the plain register port
package hcs_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CTRL0 = 5'h00;  // on, go
    localparam logic [4:0] OFF_CTRL3 = 5'h01;  // double, invert, polarities
    localparam logic [4:0] OFF_STAT = 5'h02;   // sequencer stage
    localparam logic [4:0] OFF_PRE = 5'h03;
    localparam logic [4:0] OFF_ACQ = 5'h04;
    localparam logic [4:0] OFF_GRD = 5'h05;
    localparam logic [4:0] OFF_CAP = 5'h06;
    localparam logic [4:0] OFF_RES0L = 5'h07;
    localparam logic [4:0] OFF_RES0H = 5'h08;
    localparam logic [4:0] OFF_RES1L = 5'h09;
    localparam logic [4:0] OFF_RES1H = 5'h0A;
    localparam logic [4:0] OFF_SEC = 5'h0B;
    localparam logic [4:0] OFF_TXLO = 5'h0C;
    localparam logic [4:0] OFF_TXHI = 5'h0D;
    localparam logic [4:0] OFF_TXSH = 5'h0E;
    localparam logic [4:0] OFF_IRQ = 5'h0F;    // done flag, write 1 clears
    localparam logic [4:0] OFF_CHAN = 5'h10;   // primary channel select
    // control0 bits
    localparam int B_ON = 0;
    localparam int B_GO = 1;
    // control3 bits
    localparam int B_DSEN = 6;
    localparam int B_IPEN = 1;
    localparam int B_EPPOL = 0;
    localparam int B_IPPOL = 2;
    // guard register bits
    localparam int B_GAOE = 7;
    localparam int B_GBOE = 6;
    localparam int B_GPOL = 5;
    localparam int B_TXPOL = 4;
    localparam int RES_W = 10;
    localparam int NCH = 24;                  // 8 low, 8 high, 8 shared
    localparam int BITS_W = 4;
    localparam logic [3:0] LAST_BIT = 4'h9;
    localparam logic [1:0] GAP_CYCLES = 2'h2;  // between two samples
    localparam logic [7:0] RST8 = 8'h00;
    localparam logic [3:0] STAT_IDLE = 4'h0;

    typedef enum logic [3:0] {
        HCS_IDLE = 4'h0,
        HCS_PRE1 = 4'h1,
        HCS_ACQ1 = 4'h2,
        HCS_CNV1 = 4'h3,
        HCS_GAP = 4'h4,
        HCS_PRE2 = 4'h5,
        HCS_ACQ2 = 4'h6,
        HCS_CNV2 = 4'h7,
        HCS_DONE = 4'h8
    } hcs_state_t;

    // pin-side controls that travel together
    typedef struct packed {
        logic guardA;
        logic guardB;
        logic guardAOe;
        logic guardBOe;
        logic chanDrive;      // selected pin driven during precharge
        logic chanLevel;
        logic holdBias;       // internal precharge level
        logic holdIsolate;    // mux open during precharge
        logic extraCapOn;
    } hcs_pins_t;
endpackage

/* File: hdl/hcs_sequencer.sv */
// Purpose: hardware cvd sequencer around a sar converter
// Assumes: converter returns one bit per cycle msb first on cmpBit
// Notes: special event trigger is a same-clock one-cycle pulse
`timescale 1ns/1ns
// Behaviour
// - completion clears the go flag.
// - completion sets the conversion-done interrupt flag.
// - completion loads result high and low registers.
// - go cleared during a conversion stores partial result, filling with last bit.
// - readable status register shows the current sequencer stage.
// - reset clears registers, converter off, conversion abandoned.
// - double sampling gives two conversions per start event.
// - in double mode go clears only after second conversion.
// - without inversion both samples use identical precharge levels.
// - first result goes to result pair zero.
// - second sample starts two cycles after first conversion completes.
// - inversion flips precharge and guard polarity used for sample two.
// - second result goes to result pair one.
// - guard outputs a and b, own enables, shared polarity.
// - guards active while on, polarity at precharge, toggle at acquire.
// - double plus invert inverts guard levels in second sample.
// - enabled transmit channels pulse while on, except selected channel.
// - transmit starts at polarity, toggles at acquire, inverts sample two when inversion is on.
// - four-bit extra hold capacitance, disconnected during conversion.
// - secondary channels forced input, driven like primary in precharge.
// - primary selection connects as soon as written; secondary selections only while on and outside precharge.
// - nonzero precharge count inserts that many cycles; zero skips.
// - acquisition follows precharge, or starts at the start event.
// - precharge isolates hold, biases it, drives pin; acquire releases.
// - clearing converter on halts the conversion at once.
module hcs_sequencer
(
    input wire logic ref_clk, // 250 MHz clock
    input wire logic arst_n, // async reset, low
    input wire logic [hcs_pkg::ADDR_W-1:0] regAddr, // register index
    input wire logic [7:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [7:0] regRdata, // read data, next cycle
    input wire logic trigger, // special event trigger
    input wire logic cmpBit, // sar comparator decision
    output logic convActive, // converter sampling bits
    output logic convPowered, // converter on
    output hcs_pkg::hcs_pins_t pins, // pin-side drive controls
    output logic [3:0] extraCap, // extra hold cap select
    output logic [7:0] secondaryConn, // secondary channels on bus
    output logic [7:0] secondaryDrive, // secondary output override
    output logic [5:0] primaryConn, // primary channel on bus
    output logic [hcs_pkg::NCH-1:0] txOut, // transmit levels
    output logic [hcs_pkg::NCH-1:0] txOe, // transmit drive enables
    output logic doneIrq // conversion-done flag
);
    import hcs_pkg::*;

    // ****************************************************
    // register state
    // ****************************************************
    logic [7:0] ctrl0_q, ctrl0_d, ctrl3_q, ctrl3_d, pre_q, pre_d;
    logic [7:0] acq_q, acq_d, grd_q, grd_d, cap_q, cap_d, sec_q, sec_d;
    logic [7:0] txLo_q, txLo_d, txHi_q, txHi_d, txSh_q, txSh_d;
    logic [7:0] chan_q, chan_d, rdata_q, rdata_d;
    logic [RES_W-1:0] res0_q, res0_d, res1_q, res1_d;
    logic irq_q, irq_d;
    hcs_state_t state_q, state_d;
    logic [6:0] cnt_q, cnt_d;
    logic [BITS_W-1:0] bit_q, bit_d;
    logic [RES_W-1:0] sar_q, sar_d;
    logic guard_q, guard_d, tx_q, tx_d;
    logic goSet, goClr, startEv, halt, second, inv, storeRes, lastBit;
    logic epol, ipol, gpol;
    logic [RES_W-1:0] fillRes;
    logic [NCH-1:0] txEn, selMask;

    assign second = (state_q == HCS_PRE2) || (state_q == HCS_ACQ2)
                    || (state_q == HCS_CNV2);
    // inversion only matters in the second sample of a double
    assign inv = second && ctrl3_q[B_DSEN] && ctrl3_q[B_IPEN];
    assign epol = ctrl3_q[B_EPPOL] ^ inv;
    assign ipol = ctrl3_q[B_IPPOL] ^ inv;
    assign gpol = grd_q[B_GPOL] ^ inv;
    assign goSet = regWr && regAddr == OFF_CTRL0 && regWdata[B_GO]
                   && ctrl0_q[B_ON];
    assign goClr = regWr && regAddr == OFF_CTRL0 && !regWdata[B_GO];
    assign startEv = (goSet && !ctrl0_q[B_GO] || trigger && ctrl0_q[B_ON])
                     && state_q == HCS_IDLE;
    // a write that turns the converter off stops at once, not a cycle late
    assign halt = !ctrl0_q[B_ON] || (regWr && regAddr == OFF_CTRL0
                  && !regWdata[B_ON]);
    assign lastBit = bit_q == LAST_BIT;

    // partial result: undecided bits copy the last decided bit
    always_comb
    begin
        fillRes = sar_q;
        for (int i = 0; i < RES_W; i++)
            if (i < RES_W - int'(bit_q))
                fillRes[i] = (bit_q == '0) ? 1'b0
                             : sar_q[RES_W - int'(bit_q)];
    end

    // ****************************************************
    // sequencer next state
    // ****************************************************
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        sar_d = sar_q;
        guard_d = guard_q;
        tx_d = tx_q;
        storeRes = 1'b0;
        unique case (state_q)
            HCS_IDLE:
            begin
                if (startEv)
                begin
                    // precharge skipped when its count is zero
                    if (pre_q[6:0] != '0)
                    begin
                        state_d = HCS_PRE1;
                        cnt_d = pre_q[6:0];
                        guard_d = grd_q[B_GPOL];
                        tx_d = grd_q[B_TXPOL];
                    end
                    else
                    begin
                        state_d = HCS_ACQ1;
                        cnt_d = acq_q[6:0];
                        guard_d = !grd_q[B_GPOL];
                        tx_d = !grd_q[B_TXPOL];
                    end
                end
            end
            HCS_PRE1, HCS_PRE2:
            begin
                cnt_d = cnt_q - 7'h01;
                if (cnt_q <= 7'h01)
                begin
                    state_d = second ? HCS_ACQ2 : HCS_ACQ1;
                    cnt_d = acq_q[6:0];
                    guard_d = !guard_q;
                    tx_d = !tx_q;
                end
            end
            HCS_ACQ1, HCS_ACQ2:
            begin
                cnt_d = cnt_q - 7'h01;
                if (cnt_q <= 7'h01)
                begin
                    state_d = second ? HCS_CNV2 : HCS_CNV1;
                    bit_d = '0;
                    sar_d = '0;
                end
            end
            HCS_CNV1, HCS_CNV2:
            begin
                sar_d[RES_W - 1 - int'(bit_q)] = cmpBit;
                bit_d = bit_q + 4'h1;
                if (lastBit)
                begin
                    storeRes = 1'b1;
                    if (state_q == HCS_CNV1 && ctrl3_q[B_DSEN])
                    begin
                        state_d = HCS_GAP;
                        cnt_d = {5'h00, GAP_CYCLES};
                    end
                    else
                    begin
                        state_d = HCS_DONE;
                    end
                end
            end
            HCS_GAP:
            begin
                cnt_d = cnt_q - 7'h01;
                if (cnt_q <= 7'h01)
                begin
                    // second sample starts here with go still set
                    if (pre_q[6:0] != '0)
                    begin
                        state_d = HCS_PRE2;
                        cnt_d = pre_q[6:0];
                        guard_d = gpol ^ ctrl3_q[B_IPEN];
                        tx_d = grd_q[B_TXPOL] ^ ctrl3_q[B_IPEN];
                    end
                    else
                    begin
                        state_d = HCS_ACQ2;
                        cnt_d = acq_q[6:0];
                        guard_d = !(grd_q[B_GPOL] ^ ctrl3_q[B_IPEN]);
                        tx_d = !(grd_q[B_TXPOL] ^ ctrl3_q[B_IPEN]);
                    end
                end
            end
            HCS_DONE: state_d = HCS_IDLE;
            default: state_d = HCS_IDLE;
        endcase
        // early stop by go clear, or converter turned off
        if (state_q != HCS_IDLE && (halt || goClr))
        begin
            state_d = HCS_IDLE;
        end
    end

    // ****************************************************
    // register file next values
    // ****************************************************
    always_comb
    begin
        ctrl0_d = ctrl0_q;
        ctrl3_d = ctrl3_q;
        pre_d = pre_q;
        acq_d = acq_q;
        grd_d = grd_q;
        cap_d = cap_q;
        sec_d = sec_q;
        txLo_d = txLo_q;
        txHi_d = txHi_q;
        txSh_d = txSh_q;
        chan_d = chan_q;
        res0_d = res0_q;
        res1_d = res1_q;
        irq_d = irq_q;
        if (regWr)
        begin
            unique case (regAddr)
                OFF_CTRL0: ctrl0_d = {6'h00, regWdata[B_GO] &&
                                      (ctrl0_q[B_ON] || ctrl0_q[B_GO]),
                                      regWdata[B_ON]};
                OFF_CTRL3: ctrl3_d = regWdata;
                OFF_PRE: pre_d = {1'b0, regWdata[6:0]};
                OFF_ACQ: acq_d = {1'b0, regWdata[6:0]};
                OFF_GRD: grd_d = regWdata;
                OFF_CAP: cap_d = {4'h0, regWdata[3:0]};
                OFF_SEC: sec_d = regWdata;
                OFF_TXLO: txLo_d = regWdata;
                OFF_TXHI: txHi_d = regWdata;
                OFF_TXSH: txSh_d = regWdata;
                OFF_CHAN: chan_d = {2'h0, regWdata[5:0]};
                OFF_IRQ: irq_d = irq_q && !regWdata[0];
                default: ;
            endcase
        end
        if (trigger && ctrl0_q[B_ON] && state_q == HCS_IDLE)
            ctrl0_d[B_GO] = 1'b1;
        // partial store on early go clear, no done flag
        if (goClr && state_q != HCS_IDLE && !halt)
        begin
            if (state_q == HCS_CNV2)
                res1_d = fillRes;
            else if (state_q == HCS_CNV1)
                res0_d = fillRes;
        end
        if (storeRes)
        begin
            if (state_q == HCS_CNV2)
                res1_d = sar_d;
            else
                res0_d = sar_d;
        end
        if (state_q == HCS_DONE)
        begin
            ctrl0_d[B_GO] = 1'b0;
            irq_d = 1'b1;
        end
        if (halt)
            ctrl0_d[B_GO] = 1'b0;
    end

    // read mux, answer one cycle after the strobe
    always_comb
    begin
        rdata_d = RST8;
        if (regRd)
        begin
            unique case (regAddr)
                OFF_CTRL0: rdata_d = ctrl0_q;
                OFF_CTRL3: rdata_d = ctrl3_q;
                OFF_STAT: rdata_d = {4'h0, state_q};
                OFF_PRE: rdata_d = pre_q;
                OFF_ACQ: rdata_d = acq_q;
                OFF_GRD: rdata_d = grd_q;
                OFF_CAP: rdata_d = cap_q;
                OFF_RES0L: rdata_d = res0_q[7:0];
                OFF_RES0H: rdata_d = {6'h00, res0_q[9:8]};
                OFF_RES1L: rdata_d = res1_q[7:0];
                OFF_RES1H: rdata_d = {6'h00, res1_q[9:8]};
                OFF_SEC: rdata_d = sec_q;
                OFF_TXLO: rdata_d = txLo_q;
                OFF_TXHI: rdata_d = txHi_q;
                OFF_TXSH: rdata_d = txSh_q;
                OFF_IRQ: rdata_d = {7'h00, irq_q};
                OFF_CHAN: rdata_d = chan_q;
                default: rdata_d = RST8;
            endcase
        end
    end

    // ****************************************************
    // flip-flops
    // ****************************************************
    // reset returns everything, so a pending conversion is dropped
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl0_q <= RST8;
            ctrl3_q <= RST8;
            pre_q <= RST8;
            acq_q <= RST8;
            grd_q <= RST8;
            cap_q <= RST8;
            sec_q <= RST8;
            txLo_q <= RST8;
            txHi_q <= RST8;
            txSh_q <= RST8;
            chan_q <= RST8;
            rdata_q <= RST8;
            res0_q <= '0;
            res1_q <= '0;
            irq_q <= 1'b0;
            state_q <= HCS_IDLE;
            cnt_q <= '0;
            bit_q <= '0;
            sar_q <= '0;
            guard_q <= 1'b0;
            tx_q <= 1'b0;
        end
        else
        begin
            ctrl0_q <= ctrl0_d;
            ctrl3_q <= ctrl3_d;
            pre_q <= pre_d;
            acq_q <= acq_d;
            grd_q <= grd_d;
            cap_q <= cap_d;
            sec_q <= sec_d;
            txLo_q <= txLo_d;
            txHi_q <= txHi_d;
            txSh_q <= txSh_d;
            chan_q <= chan_d;
            rdata_q <= rdata_d;
            res0_q <= res0_d;
            res1_q <= res1_d;
            irq_q <= irq_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sar_q <= sar_d;
            guard_q <= guard_d;
            tx_q <= tx_d;
        end
    end

    // ****************************************************
    // pin-side outputs
    // ****************************************************
    assign txEn = {txSh_q, txHi_q, txLo_q};
    // the channel under conversion never transmits
    generate
        for (genvar g = 0; g < NCH; g++)
        begin : gTx
            assign selMask[g] = chan_q[5:0] == 6'(g);
            assign txOe[g] = txEn[g] && ctrl0_q[B_ON] && !selMask[g];
            assign txOut[g] = tx_q && txOe[g];
        end
    endgenerate

    assign regRdata = rdata_q;
    assign doneIrq = irq_q;
    assign convPowered = ctrl0_q[B_ON];
    assign convActive = state_q == HCS_CNV1 || state_q == HCS_CNV2;
    assign pins.guardAOe = grd_q[B_GAOE] && ctrl0_q[B_ON];
    assign pins.guardBOe = grd_q[B_GBOE] && ctrl0_q[B_ON];
    assign pins.guardA = guard_q && pins.guardAOe;
    assign pins.guardB = guard_q && pins.guardBOe;
    assign pins.holdIsolate = state_q == HCS_PRE1 || state_q == HCS_PRE2;
    assign pins.chanDrive = pins.holdIsolate;
    assign pins.chanLevel = epol && pins.holdIsolate;
    assign pins.holdBias = ipol && pins.holdIsolate;
    // extra cap stays off the bus while bits are decided
    assign pins.extraCapOn = ctrl0_q[B_ON] && !convActive;
    assign extraCap = pins.extraCapOn ? cap_q[3:0] : 4'h0;
    assign secondaryConn = ctrl0_q[B_ON] && !pins.holdIsolate
                           ? sec_q : 8'h00;
    assign secondaryDrive = pins.holdIsolate ? sec_q : 8'h00;
    assign primaryConn = chan_q[5:0];
endmodule

/* File: tb/hcs_props.sv */
// Purpose: port checks for the cvd sequencer
// Assumes: one clock, async active-low reset
// Notes: bound to every hcs_sequencer instance
`timescale 1ns/1ns
module hcs_props
    import hcs_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic arst_n, // reset, low
    input wire logic regRd, // read strobe
    input wire logic [7:0] regRdata, // read data
    input wire logic convActive, // converting
    input wire logic convPowered, // converter on
    input wire hcs_pkg::hcs_pins_t pins, // pin controls
    input wire logic [7:0] secondaryConn, // secondary on bus
    input wire logic [7:0] secondaryDrive, // secondary override
    input wire logic [hcs_pkg::NCH-1:0] txOut, // tx levels
    input wire logic [hcs_pkg::NCH-1:0] txOe, // tx enables
    input wire logic doneIrq // done flag
);
    // ************************************
    // checks
    // ************************************
    logic [3:0] runQ;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // cycles spent converting
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            runQ <= 4'h0;
        else
            runQ <= convActive ? runQ + 4'h1 : 4'h0;
    sequence s_acq_start;
        $fell(pins.holdIsolate);
    endsequence
    a_conv_len: assert property (convActive |-> runQ < 4'hA)
        else $error("conversion longer than ten cycles");
    a_done_after: assert property ($rose(doneIrq) |->
        $past(convActive, 2) && !$past(convActive))
        else $error("done flag not one cycle after conversion");
    a_cap_off: assert property (convActive |-> !pins.extraCapOn)
        else $error("extra capacitance during conversion");
    a_cap_on: assert property (pins.extraCapOn |-> convPowered)
        else $error("extra capacitance while off");
    a_pre_isolate: assert property (pins.holdIsolate |->
        pins.chanDrive && !convActive)
        else $error("precharge without pin drive");
    a_sec_drive: assert property (secondaryDrive != 8'h00 |->
        pins.holdIsolate && secondaryConn == 8'h00)
        else $error("secondary override outside precharge");
    a_off_quiet: assert property (!convPowered |-> !convActive &&
        txOe == '0 && !pins.guardAOe && !pins.guardBOe)
        else $error("activity while converter off");
    a_guard_flip: assert property (s_acq_start ##0
        (pins.guardAOe && $past(pins.guardAOe)) |->
        pins.guardA != $past(pins.guardA))
        else $error("guard did not toggle at acquisition");
    a_tx_flip: assert property (s_acq_start ##0 (txOe[0] && $past(txOe[0]))
        |-> txOut[0] != $past(txOut[0]))
        else $error("tx did not toggle at acquisition");
    a_rd_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data outside read slot");
endmodule
bind hcs_sequencer hcs_props u_props (.ref_clk(ref_clk), .arst_n(arst_n),
    .regRd(regRd), .regRdata(regRdata), .convActive(convActive),
    .convPowered(convPowered), .pins(pins), .txOut(txOut), .txOe(txOe),
    .secondaryConn(secondaryConn), .secondaryDrive(secondaryDrive),
    .doneIrq(doneIrq));

/* File: tb/hcs_sensor.sv */
// Purpose: sensor and comparator seen by the sequencer
// Assumes: one decision per conversion cycle, msb first
// Notes: level is set by the bench per conversion
`timescale 1ns/1ns
module hcs_sensor
    import hcs_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic arst_n, // reset, low
    input wire logic convActive, // design converting
    input wire logic [hcs_pkg::RES_W-1:0] level, // value to report
    output logic cmpBit // comparator decision
);
    logic [3:0] idxQ;
    logic junkQ;
    // bit index walks through one conversion
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
        begin
            idxQ <= 4'h0;
            junkQ <= 1'b0;
        end
        else
        begin
            idxQ <= convActive ? idxQ + 4'h1 : 4'h0;
            junkQ <= !junkQ;
        end
    // churn between conversions so a stale bit never looks valid
    assign cmpBit = convActive ? level[4'h9 - idxQ] : junkQ;
endmodule

/* File: tb/hcs_sequencer_bench.sv */
// Purpose: self-checking bench for the cvd sequencer
// Assumes: sensor model answers every conversion
// Notes: each scenario is one task
`timescale 1ns/1ns
module hcs_sequencer_bench;
    import hcs_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic trigger = 1'b0;
    logic [9:0] level = 10'h000;
    logic [7:0] regRdata, secondaryConn, secondaryDrive;
    logic cmpBit, convActive, convPowered, doneIrq;
    hcs_pins_t pins;
    logic [3:0] extraCap;
    logic [5:0] primaryConn;
    logic [NCH-1:0] txOut, txOe;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    hcs_sequencer dut (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .trigger(trigger),
        .regRdata(regRdata), .cmpBit(cmpBit), .convActive(convActive),
        .convPowered(convPowered), .pins(pins), .extraCap(extraCap),
        .secondaryConn(secondaryConn), .secondaryDrive(secondaryDrive),
        .primaryConn(primaryConn), .txOut(txOut), .txOe(txOe),
        .doneIrq(doneIrq));
    hcs_sensor sensor (.ref_clk(ref_clk), .arst_n(arst_n),
        .convActive(convActive), .level(level), .cmpBit(cmpBit));
    // ************************************
    // helpers
    // ************************************
    initial
        forever #2 ref_clk = ~ref_clk;
    // hang guard, far above a normal run
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // look just after the next edge
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rc(input string nm, input logic [4:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 chk(nm, e, regRdata);
    endtask
    // wait for done, counting conversion cycles
    task automatic run(output int n);
        n = 0;
        for (int i = 0; i < 200 && doneIrq !== 1'b1; i++)
        begin
            tick();
            n += (convActive === 1'b1);
        end
    endtask
    // ************************************
    // scenarios
    // ************************************
    task automatic t_reset();
        rc("ctrl0", OFF_CTRL0, 8'h00);
        rc("stat", OFF_STAT, STAT_IDLE);
        rc("res0l", OFF_RES0L, 8'h00);
        rc("unmapped", 5'h1F, 8'h00);
        chk("flags", 0, {pins, convPowered, convActive, doneIrq});
    endtask
    task automatic t_chan();
        wr(OFF_CTRL0, 8'h01);
        wr(OFF_CHAN, 8'h01);
        wr(OFF_SEC, 8'h05);
        wr(OFF_TXLO, 8'h03);
        wr(OFF_GRD, 8'hD0);
        tick();
        chk("primary", 1, primaryConn);
        chk("secondary", 8'h05, secondaryConn);
        chk("txOe", 1, txOe);
        chk("guardOe", 3, {pins.guardAOe, pins.guardBOe});
    endtask
    task automatic t_single();
        int n;
        level <= 10'h2B5;
        wr(OFF_ACQ, 8'h03);
        wr(OFF_CTRL0, 8'h03);
        rc("stat", OFF_STAT, 8'h02);
        run(n);
        chk("convlen", 10, n);
        chk("irq", 1, doneIrq);
        rc("ctrl0", OFF_CTRL0, 8'h01);
        rc("res0l", OFF_RES0L, 8'hB5);
        rc("res0h", OFF_RES0H, 8'h02);
        wr(OFF_IRQ, 8'h01);
        tick();
        chk("irqclr", 0, doneIrq);
    endtask
    task automatic t_double(input logic inv);
        int pre = 0, gap = 0, ph = 0, n;
        logic g1, c1;
        level <= 10'h155;
        wr(OFF_PRE, 8'h03);
        wr(OFF_ACQ, 8'h02);
        wr(OFF_CTRL3, {6'h10, inv, 1'b1});
        if (inv)
            wr(OFF_CTRL0, 8'h03);
        else
        begin
            @(posedge ref_clk);
            trigger <= 1'b1;
            @(posedge ref_clk);
            trigger <= 1'b0;
        end
        // follow the walk up to the second precharge, from the start edge
        #1;
        for (int i = 0; i < 80 && ph < 3; i++)
        begin
            if (ph == 0 && pins.holdIsolate === 1'b1)
            begin
                if (pre == 0)
                    {g1, c1} = {pins.guardA, pins.chanLevel};
                pre++;
            end
            else if (ph == 0 && convActive === 1'b1)
                ph = 1;
            else if (ph == 1 && convActive !== 1'b1)
            begin
                ph = 2;
                gap = 1;
                level <= 10'h2AA;
            end
            else if (ph == 2 && pins.holdIsolate !== 1'b1)
                gap++;
            else if (ph == 2)
            begin
                ph = 3;
                chk("chan2", {c1 ^ inv, inv},
                    {pins.chanLevel, pins.holdBias});
                chk("guard2", g1 ^ inv, pins.guardA);
            end
            tick();
        end
        chk("pre", 3, pre);
        chk("gap", 2, gap);
        chk("lev1", 2'b01, {g1, c1});
        rc("go2", OFF_CTRL0, 8'h03);
        run(n);
        chk("conv2", 10, n);
        rc("res0l", OFF_RES0L, 8'h55);
        rc("res0h", OFF_RES0H, 8'h01);
        rc("res1l", OFF_RES1L, 8'hAA);
        rc("res1h", OFF_RES1H, 8'h02);
        rc("goend", OFF_CTRL0, 8'h01);
        wr(OFF_IRQ, 8'h01);
    endtask
    task automatic t_abort();
        level <= 10'h3F0;
        wr(OFF_CTRL3, 8'h00);
        wr(OFF_CAP, 8'h05);
        tick();
        chk("cap", 5'h15, {pins.extraCapOn, extraCap});
        wr(OFF_CTRL0, 8'h03);
        for (int i = 0; i < 40 && convActive !== 1'b1; i++)
            tick();
        wr(OFF_CTRL0, 8'h01);
        rc("res0l", OFF_RES0L, 8'hFF);
        rc("res0h", OFF_RES0H, 8'h03);
        chk("noirq", 0, doneIrq);
        wr(OFF_CTRL0, 8'h03);
        for (int i = 0; i < 40 && convActive !== 1'b1; i++)
            tick();
        wr(OFF_CTRL0, 8'h00);
        rc("halt", OFF_STAT, STAT_IDLE);
        chk("off", 0, {txOe, convActive});
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_chan();
        t_single();
        t_double(1'b0);
        t_double(1'b1);
        t_abort();
        wr(OFF_CTRL0, 8'h01);
        wr(OFF_CTRL0, 8'h03);
        repeat (3) tick();
        arst_n <= 1'b0;
        tick();
        arst_n <= 1'b1;
        t_reset();
        test_done();
    end
endmodule
